// *** rtl/itar_pkg.sv ***
// ==================================================================
// Register map, field layout and timing constants.
package itar_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_SAR1 = 8'hD6;
   localparam logic [7:0] IDX_SAR0 = 8'hD7;
   localparam logic [7:0] IDX_CTL = 8'hD8;
   localparam logic [7:0] IDX_IEN = 8'hD9;
   localparam logic [7:0] IDX_ICLR = 8'hDA;
   localparam logic [7:0] IDX_STAT = 8'hDB;
   localparam logic [7:0] IDX_CLOCK_LOW_COUNT = 8'hDC;
   localparam logic [7:0] IDX_CLOCK_HIGH_COUNT = 8'hDD;
   localparam logic [7:0] IDX_DATA_HOLD_COUNT = 8'hDE;
   localparam logic [7:0] IDX_DATA = 8'hDF;

   // Reset values.
   localparam logic [7:0] SAR_RST = 8'h00;
   localparam logic [7:0] CLOCK_LOW_COUNT_RST = 8'h3F;
   localparam logic [7:0] CLOCK_HIGH_COUNT_RST = 8'h3F;
   localparam logic [7:0] DATA_HOLD_COUNT_RST = 8'h01;
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic [4:0] CTL_RST = 5'h00;
   localparam logic [7:0] IEN_RST = 8'h00;

   // Control register fields.
   localparam int CTL_START = 0;
   localparam int CTL_STOP = 1;
   localparam int CTL_MASTER = 2;
   localparam int CTL_ACKNOWLEDGE_ENABLE = 3;
   localparam int CTL_EN = 4;

   // Status register fields.
   localparam int ST_RECEIVED_ACK_FLAG = 0;
   localparam int ST_TMODE = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_LOST = 3;
   localparam int ST_SSEL = 4;
   localparam int ST_STOPD = 5;
   localparam int ST_BDONE = 6;
   localparam int ST_GCALL = 7;
   // Bits cleared by a status write, and bits that may interrupt.
   localparam logic [7:0] STAT_CLR_MASK = 8'h79;
   localparam logic [7:0] STAT_IRQ_MASK = 8'h78;
   // Interrupts that stretch SCL: all but stop detection.
   localparam logic [7:0] STAT_HOLD_MASK = 8'h58;

   // SCL low = 4*L+1, high = 4*H+3, SDA hold = hold+1 system clocks.
   localparam int SCL_MUL = 4;
   localparam int SCL_LOW_ADD = 1;
   localparam int SCL_HIGH_ADD = 3;
   localparam int SDA_HOLD_ADD = 1;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_PRE = 4'hF;

endpackage

// *** rtl/itar_sync.sv ***
`timescale 1ns/1ps
// ==================================================================
// Three-flop input synchroniser with agreement filter.
module itar_sync import itar_pkg::*; (
   input wire logic clk, // System clock.
   input wire logic reset, // Synchronous reset, active high.
   input wire logic [1:0] pin_i, // Raw pin levels.
   output logic [1:0] lvl_o // Filtered levels.
);

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic lv_r;
         // The first flop feeds only the second; a level change is
         // taken once the second and third stages agree.
         always_ff @(posedge clk) begin
            if (reset) begin
               s1_r <= 1'b1;
               s2_r <= 1'b1;
               s3_r <= 1'b1;
               lv_r <= 1'b1;
            end else begin
               s1_r <= pin_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  lv_r <= s3_r;
               end
            end
         end
         assign lvl_o[g] = lv_r;
      end
   endgenerate

endmodule // itar_sync

// *** rtl/itar_core.sv ***
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// ==================================================================
// Two-wire bus controller: timing, address and data registers.
// Function
// RL1 - Pending non-stop interrupt holds SCL low; held only in ST_XFER, so not after lost, which moves to ST_SKIP
// RL2 - Status write releases SCL, clears flags
// RL3 - Done, stop, select, lost raise interrupt
// RL4 - Master SCL low lasts 4*low+1 clocks
// RL5 - Master SCL high lasts 4*high+3 clocks
// RL6 - SDA changes hold+1 clocks after fall
// RL7 - Software sets hold near half low count
// RL8 - Slave hold+1 shorter than remote period
// RL9 - Transmitter shifts out the data byte
// RL10 - Receiver stores each byte in data
// RL11 - Address bits 7..1 compared as slave
// RL12 - Bit 0 enables general call acceptance
// RL13 - Second address register, same layout, reset
// RL14 - Match on either address selects slave
// RL15 - Acknowledge on match, general call, reception
// RL16 - Counters reload at each SCL phase
module itar_core import itar_pkg::*; (
   input wire logic clk, // System clock, 25 MHz.
   input wire logic reset, // Synchronous reset, active high.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction, high for write.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data, registered.
   output logic pready, // APB ready, always high.
   output logic pslverr, // APB error on unmapped address.
   input wire logic scl_i, // SCL pin level.
   output logic scl_o, // SCL output value, always low.
   output logic scl_oe, // SCL pulled low while high.
   input wire logic sda_i, // SDA pin level.
   output logic sda_o, // SDA output value, always low.
   output logic sda_oe, // SDA pulled low while high.
   output logic irq // Level interrupt request.
);

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_BEGIN = 5'h02,
      ST_XFER = 5'h04,
      ST_END = 5'h08,
      ST_SKIP = 5'h10
   } itar_state_t;

   typedef struct packed {
      itar_state_t st;
      logic [7:0] sar0;
      logic [7:0] sar1;
      logic [7:0] clock_low_count;
      logic [7:0] clock_high_count;
      logic [7:0] data_hold_count;
      logic [7:0] dbyte;
      logic [4:0] ctl;
      logic [7:0] stat;
      logic [7:0] ien;
      logic [7:0] shreg;
      logic [3:0] bitcnt;
      logic [9:0] tmr;
      logic [7:0] hcnt;
      logic hrun;
      logic ph_hi;
      logic scl_drv;
      logic sda_drv;
      logic addr_ph;
      logic scl_p;
      logic sda_p;
      logic sclo;
      logic irq;
      logic [31:0] prdata;
   } itar_regs_t;

   localparam itar_regs_t REGS_RST = '{st: ST_IDLE, sar0: SAR_RST, sar1: SAR_RST,
      clock_low_count: CLOCK_LOW_COUNT_RST, clock_high_count: CLOCK_HIGH_COUNT_RST, data_hold_count: DATA_HOLD_COUNT_RST, dbyte: DATA_RST, ctl: CTL_RST,
      ien: IEN_RST, bitcnt: BIT_PRE, scl_p: 1'b1, sda_p: 1'b1, default: '0};

   itar_regs_t s_r;
   itar_regs_t s_nxt;
   logic [1:0] lvl;
   logic scl_f;
   logic sda_f;

   // ==================================================================
   // Helpers.
   // Register index match on an aligned word address.
   function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
      return (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
   endfunction

   // Period reload values, one less than the cycle counts.
   function automatic logic [9:0] low_load(input logic [7:0] l);
      return 10'((SCL_MUL * int'(l)) + SCL_LOW_ADD - 1);
   endfunction

   function automatic logic [9:0] high_load(input logic [7:0] h);
      return 10'((SCL_MUL * int'(h)) + SCL_HIGH_ADD - 1);
   endfunction

   // Address match on either own-address register.
   function automatic logic addr_match(input logic [7:0] a, input logic [7:0] r);
      return (a[7:1] == r[7:1]) && (r[7:1] != 7'h00);
   endfunction

   // ==================================================================
   // Pin synchronisers.
   itar_sync u_sync (
      .clk(clk),
      .reset(reset),
      .pin_i({sda_i, scl_i}),
      .lvl_o(lvl)
   );
   assign scl_f = lvl[0];
   assign sda_f = lvl[1];

   // ==================================================================
   // Next-state logic for the whole block.
   always_comb begin
      logic wr;
      logic hold_b;
      logic hold_a;
      logic mst;
      logic tx_now;
      logic fall_ev;
      logic gc;
      logic hit;
      s_nxt = s_r;
      wr = psel && penable && pwrite;
      hold_b = |(s_r.stat & STAT_HOLD_MASK);
      hold_a = 1'b0;
      mst = s_r.ctl[CTL_MASTER];
      tx_now = s_r.addr_ph ? mst : s_r.stat[ST_TMODE];
      fall_ev = 1'b0;
      gc = 1'b0;
      hit = 1'b0;
      s_nxt.scl_p = scl_f;
      s_nxt.sda_p = sda_f;

      // Register writes; hardware events below win over clears.
      if (wr) begin
         if (idx_hit(paddr, IDX_SAR0)) s_nxt.sar0 = pwdata[7:0]; // RL11
         if (idx_hit(paddr, IDX_SAR1)) s_nxt.sar1 = pwdata[7:0]; // RL13
         if (idx_hit(paddr, IDX_CLOCK_LOW_COUNT)) s_nxt.clock_low_count = pwdata[7:0];
         if (idx_hit(paddr, IDX_CLOCK_HIGH_COUNT)) s_nxt.clock_high_count = pwdata[7:0];
         if (idx_hit(paddr, IDX_DATA_HOLD_COUNT)) s_nxt.data_hold_count = pwdata[7:0];
         if (idx_hit(paddr, IDX_DATA)) s_nxt.dbyte = pwdata[7:0]; // RL9
         if (idx_hit(paddr, IDX_CTL)) s_nxt.ctl = pwdata[4:0];
         if (idx_hit(paddr, IDX_IEN)) s_nxt.ien = pwdata[7:0];
         if (idx_hit(paddr, IDX_STAT)) s_nxt.stat = s_r.stat & ~STAT_CLR_MASK; // RL2
         if (idx_hit(paddr, IDX_ICLR)) s_nxt.stat = s_nxt.stat & ~pwdata[7:0];
      end

      // Read data is latched in the setup phase so it is stable in access.
      if (psel && !penable) begin
         s_nxt.prdata = 32'h0000_0000;
         if (idx_hit(paddr, IDX_SAR0)) s_nxt.prdata[7:0] = s_r.sar0;
         if (idx_hit(paddr, IDX_SAR1)) s_nxt.prdata[7:0] = s_r.sar1;
         if (idx_hit(paddr, IDX_CLOCK_LOW_COUNT)) s_nxt.prdata[7:0] = s_r.clock_low_count;
         if (idx_hit(paddr, IDX_CLOCK_HIGH_COUNT)) s_nxt.prdata[7:0] = s_r.clock_high_count;
         if (idx_hit(paddr, IDX_DATA_HOLD_COUNT)) s_nxt.prdata[7:0] = s_r.data_hold_count;
         if (idx_hit(paddr, IDX_DATA)) s_nxt.prdata[7:0] = s_r.dbyte; // RL10
         if (idx_hit(paddr, IDX_CTL)) s_nxt.prdata[4:0] = s_r.ctl;
         if (idx_hit(paddr, IDX_IEN)) s_nxt.prdata[7:0] = s_r.ien;
         if (idx_hit(paddr, IDX_STAT)) s_nxt.prdata[7:0] = s_r.stat;
      end

      // Start and stop conditions seen on the bus while SCL is high.
      if (scl_f && s_r.scl_p && s_r.sda_p && !sda_f) begin
         s_nxt.stat[ST_BUSY] = 1'b1;
         if (s_r.st != ST_BEGIN) begin
            s_nxt.st = ST_XFER;
            s_nxt.addr_ph = 1'b1;
            s_nxt.bitcnt = BIT_PRE;
            s_nxt.stat[ST_TMODE] = 1'b0;
            s_nxt.ctl[CTL_MASTER] = 1'b0;
         end
      end else if (scl_f && s_r.scl_p && !s_r.sda_p && sda_f) begin
         s_nxt.stat[ST_BUSY] = 1'b0;
         s_nxt.stat[ST_STOPD] = 1'b1; // RL3
         s_nxt.st = ST_IDLE;
         s_nxt.addr_ph = 1'b0;
         s_nxt.sda_drv = 1'b0;
         s_nxt.scl_drv = 1'b0;
         s_nxt.hrun = 1'b0;
      end else begin
         case (s_r.st)
            ST_IDLE: begin
               if (s_r.ctl[CTL_START] && mst && !s_r.stat[ST_BUSY]) begin
                  s_nxt.st = ST_BEGIN;
                  s_nxt.sda_drv = 1'b1;
                  s_nxt.tmr = high_load(s_r.clock_high_count);
                  s_nxt.ctl[CTL_START] = 1'b0;
               end
            end
            ST_BEGIN: begin
               // Start hold, then the first low phase with the address byte.
               if (s_r.tmr != 10'h000) begin
                  s_nxt.tmr = s_r.tmr - 10'h001;
               end else begin
                  s_nxt.st = ST_XFER;
                  s_nxt.scl_drv = 1'b1;
                  s_nxt.ph_hi = 1'b0;
                  s_nxt.tmr = low_load(s_r.clock_low_count); // RL4
                  s_nxt.bitcnt = 4'h0;
                  s_nxt.addr_ph = 1'b1;
                  s_nxt.shreg = s_r.dbyte; // RL9
                  s_nxt.hrun = 1'b1;
                  s_nxt.hcnt = s_r.data_hold_count; // RL6
               end
            end
            ST_XFER: begin
               if (mst) begin
                  // Master clock generation; a held bus pauses the low phase.
                  if (s_r.ph_hi) begin
                     if (s_r.tmr != 10'h000) begin
                        s_nxt.tmr = s_r.tmr - 10'h001;
                     end else if (scl_f) begin
                        s_nxt.scl_drv = 1'b1;
                        s_nxt.ph_hi = 1'b0;
                        s_nxt.tmr = low_load(s_r.clock_low_count); // RL16
                        fall_ev = 1'b1;
                     end
                  end else if (s_r.tmr != 10'h000) begin
                     s_nxt.tmr = s_r.tmr - 10'h001;
                  end else if (!hold_b) begin
                     s_nxt.scl_drv = 1'b0;
                     s_nxt.ph_hi = 1'b1;
                     s_nxt.tmr = high_load(s_r.clock_high_count); // RL5
                  end
               end else begin
                  fall_ev = s_r.scl_p && !scl_f;
               end
               // Sample on the rising edge; the ack bit is not shifted in.
               if (scl_f && !s_r.scl_p && s_r.bitcnt != BIT_PRE) begin
                  if (s_r.bitcnt == BIT_ACK) begin
                     if (tx_now) s_nxt.stat[ST_RECEIVED_ACK_FLAG] = ~sda_f;
                     if (mst && s_r.addr_ph) s_nxt.stat[ST_GCALL] = ~sda_f;
                  end else begin
                     s_nxt.shreg = {s_r.shreg[6:0], sda_f};
                     if (mst && tx_now && !s_r.sda_drv && !sda_f) begin
                        s_nxt.stat[ST_LOST] = 1'b1; // RL3
                        s_nxt.ctl[CTL_MASTER] = 1'b0;
                        s_nxt.scl_drv = 1'b0;
                        s_nxt.sda_drv = 1'b0;
                        s_nxt.st = ST_SKIP;
                     end
                  end
               end
               // Falling edge: advance the bit and restart the hold delay.
               if (fall_ev) begin
                  s_nxt.hrun = 1'b1;
                  s_nxt.hcnt = s_r.data_hold_count; // RL6
                  if (s_r.bitcnt == BIT_ACK) begin
                     s_nxt.bitcnt = 4'h0;
                     s_nxt.stat[ST_BDONE] = 1'b1; // RL3
                     s_nxt.addr_ph = 1'b0;
                     if (s_r.addr_ph && mst) s_nxt.stat[ST_TMODE] = ~s_r.shreg[0];
                     if (!tx_now) s_nxt.dbyte = s_r.shreg; // RL10
                  end else begin
                     s_nxt.bitcnt = s_r.bitcnt + 4'h1;
                     if (s_r.bitcnt == 4'h7 && s_r.addr_ph && !mst) begin
                        gc = (s_r.shreg == 8'h00) && (s_r.sar0[0] || s_r.sar1[0]); // RL12
                        hit = addr_match(s_r.shreg, s_r.sar0)
                           || addr_match(s_r.shreg, s_r.sar1); // RL14
                        if (hit || gc) begin
                           s_nxt.stat[ST_SSEL] = 1'b1; // RL11
                           s_nxt.stat[ST_GCALL] = gc;
                           s_nxt.stat[ST_TMODE] = s_r.shreg[0];
                        end else begin
                           s_nxt.st = ST_SKIP;
                           s_nxt.hrun = 1'b0;
                        end
                     end
                  end
               end else if (s_r.hrun) begin
                  if (s_r.hcnt != 8'h00) begin
                     s_nxt.hcnt = s_r.hcnt - 8'h01;
                  end else begin
                     s_nxt.hrun = 1'b0;
                     if (s_r.bitcnt == BIT_ACK) begin
                        s_nxt.sda_drv = !tx_now && s_r.ctl[CTL_ACKNOWLEDGE_ENABLE]; // RL15
                     end else begin
                        s_nxt.sda_drv = tx_now && !s_r.shreg[7]; // RL9
                     end
                  end
               end
            end
            ST_END: begin
               // Stop: SDA low through a low phase, release SCL, then SDA.
               if (s_r.tmr != 10'h000) begin
                  s_nxt.tmr = s_r.tmr - 10'h001;
               end else if (!s_r.ph_hi) begin
                  s_nxt.scl_drv = 1'b0;
                  s_nxt.ph_hi = 1'b1;
                  s_nxt.tmr = high_load(s_r.clock_high_count); // RL5
               end else if (scl_f) begin
                  s_nxt.sda_drv = 1'b0;
                  s_nxt.ctl[CTL_STOP] = 1'b0;
                  s_nxt.st = ST_IDLE;
               end
            end
            ST_SKIP: begin
               s_nxt.sda_drv = 1'b0;
            end
            default: begin
               s_nxt.st = ST_IDLE;
            end
         endcase
      end

      // Release of a held bus: a master with stop set starts the stop; otherwise reload the byte when transmitting and replay the hold delay.
      hold_a = |(s_nxt.stat & STAT_HOLD_MASK);
      if (hold_b && !hold_a && s_r.st == ST_XFER && s_nxt.st == ST_XFER) begin
         if (mst && s_r.ctl[CTL_STOP]) begin
            s_nxt.st = ST_END;
            s_nxt.sda_drv = 1'b1;
            s_nxt.ph_hi = 1'b0;
            s_nxt.tmr = low_load(s_r.clock_low_count);
            s_nxt.hrun = 1'b0;
         end else begin
            if (s_nxt.stat[ST_TMODE]) s_nxt.shreg = s_nxt.dbyte; // RL9
            s_nxt.hrun = 1'b1;
            s_nxt.hcnt = s_r.data_hold_count;
            // A fresh low phase, so the replayed SDA change lands while SCL is low.
            if (mst) s_nxt.tmr = low_load(s_r.clock_low_count); // RL16
         end
      end

      // A disabled controller lets go of both lines.
      if (!s_nxt.ctl[CTL_EN]) begin
         s_nxt.st = ST_IDLE;
         s_nxt.scl_drv = 1'b0;
         s_nxt.sda_drv = 1'b0;
         s_nxt.hrun = 1'b0;
      end

      // Stretch SCL while a non-stop interrupt is pending and the state is ST_XFER.
      s_nxt.sclo = s_nxt.scl_drv || (hold_a && s_nxt.st == ST_XFER); // RL1
      s_nxt.irq = |(s_nxt.stat & s_nxt.ien & STAT_IRQ_MASK); // RL3
   end

   // ==================================================================
   // State register.
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= REGS_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==================================================================
   // Outputs. The bus never waits, so a transfer takes two cycles.
   assign prdata = s_r.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !(idx_hit(paddr, IDX_SAR0)
      || idx_hit(paddr, IDX_SAR1) || idx_hit(paddr, IDX_CLOCK_LOW_COUNT)
      || idx_hit(paddr, IDX_CLOCK_HIGH_COUNT) || idx_hit(paddr, IDX_DATA_HOLD_COUNT)
      || idx_hit(paddr, IDX_DATA) || idx_hit(paddr, IDX_CTL)
      || idx_hit(paddr, IDX_IEN) || idx_hit(paddr, IDX_ICLR)
      || idx_hit(paddr, IDX_STAT));
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = s_r.sclo;
   assign sda_oe = s_r.sda_drv;
   assign irq = s_r.irq;

endmodule // itar_core

// *** dv/itar_chk.sv ***
`timescale 1ns/1ps
// ==================================================================
// Port-level checker for the two-wire controller.
module itar_chk import itar_pkg::*; (
   input wire logic clk, // System clock.
   input wire logic reset, // Synchronous reset.
   input wire logic psel, // Select.
   input wire logic penable, // Enable.
   input wire logic pwrite, // Direction.
   input wire logic [11:0] paddr, // Byte address.
   input wire logic [31:0] pwdata, // Write data.
   input wire logic [31:0] prdata, // Read data.
   input wire logic pslverr, // Error.
   input wire logic scl_oe, // SCL pull-down.
   input wire logic sda_oe, // SDA pull-down.
   input wire logic irq // Interrupt.
);
   logic [7:0] lo_r, hi_r, hd_r;
   logic [9:0] cl_r, ch_r;
   logic hld_r, act_r;
   wire wr = psel && penable && pwrite;
   wire [7:0] wi = paddr[9:2];

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ==================================================================
   // Shadow counts and phase lengths. Stretched phases are skipped, since
   // software decides how long they last.
   always_ff @(posedge clk) begin
      if (reset) begin
         lo_r <= CLOCK_LOW_COUNT_RST;
         hi_r <= CLOCK_HIGH_COUNT_RST;
         hd_r <= DATA_HOLD_COUNT_RST;
         hld_r <= 1'b0;
         act_r <= 1'b0;
      end else begin
         if (wr && wi == IDX_CLOCK_LOW_COUNT) lo_r <= pwdata[7:0];
         if (wr && wi == IDX_CLOCK_HIGH_COUNT) hi_r <= pwdata[7:0];
         if (wr && wi == IDX_DATA_HOLD_COUNT) hd_r <= pwdata[7:0];
         hld_r <= scl_oe && (hld_r || irq);
         if (scl_oe) act_r <= 1'b1;
         else if ($fell(sda_oe)) act_r <= 1'b0;
      end
      cl_r <= scl_oe ? cl_r + 10'h001 : 10'h000;
      ch_r <= scl_oe ? 10'h000 : ch_r + 10'h001;
   end

   // ==================================================================
   // Properties.
   property p_low;
      $fell(scl_oe) && !hld_r |-> cl_r == 4 * lo_r + 1;
   endproperty
   a_low: assert property (p_low) else $error("SCL low period off");
   property p_high;
      $rose(scl_oe) && act_r |-> ch_r == 4 * hi_r + 3;
   endproperty
   a_high: assert property (p_high) else $error("SCL high period off");
   property p_hold;
      $changed(sda_oe) && scl_oe && $past(scl_oe) && !hld_r |-> cl_r == hd_r + 1;
   endproperty
   a_hold: assert property (p_hold) else $error("SDA moved at wrong time");
   property p_stick;
      irq && scl_oe && !(psel && pwrite) && !$past(psel && pwrite) |=> scl_oe;
   endproperty
   a_stick: assert property (p_stick) else $error("SCL let go while pending");
   property p_rel;
      wr && wi == IDX_STAT && scl_oe && lo_r < 8'hC8 |-> ##[1:900] !scl_oe;
   endproperty
   a_rel: assert property (p_rel) else $error("SCL not released");
   property p_irq;
      wr && wi == IDX_STAT |-> ##[1:2] !irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq kept after status write");
   property p_mask;
      wr && wi == IDX_IEN && pwdata[7:0] == 8'h00 |-> ##[1:2] !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq kept while masked");
   property p_err;
      psel && penable |-> pslverr == !(paddr[1:0] == 2'b00 && paddr[11:2] >= 10'h0D6
         && paddr[11:2] <= 10'h0DF);
   endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_rdz;
      psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000;
   endproperty
   a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
endmodule // itar_chk

bind itar_core itar_chk u_chk (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pslverr, .scl_oe, .sda_oe, .irq);

// *** dv/itar_peer.sv ***
`timescale 1ns/1ps
// ==================================================================
// Far-side target: acknowledges any address, takes one byte on a write,
// returns a fixed byte on a read. It never stretches the clock.
module itar_peer #(
   parameter logic [7:0] RD_BYTE = 8'h3C // Byte returned on a read.
) (
   input wire logic scl, // Bus clock level.
   input wire logic sda, // Bus data level.
   output logic sda_low, // Pulls the data line low.
   output logic [7:0] got, // Byte taken on the last write.
   output logic mack // Acknowledge level seen after a read byte.
);
   logic [7:0] adr;

   // Eight bits, MSB first, sampled on rising clock edges.
   task automatic shift(output logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         @(posedge scl);
         v = {v[6:0], sda};
      end
   endtask

   // Hold data low across the ninth clock.
   task automatic ackb();
      @(negedge scl);
      sda_low = 1'b1;
      @(negedge scl);
      sda_low = 1'b0;
   endtask

   // One transfer per start; a released line floats high on its pull-up.
   initial begin
      sda_low = 1'b0;
      got = 8'h00;
      mack = 1'b1;
      forever begin
         @(negedge sda iff scl === 1'b1);
         shift(adr);
         ackb();
         if (adr[0]) begin
            for (int i = 7; i >= 0; i--) begin
               sda_low = !RD_BYTE[i];
               @(negedge scl);
            end
            sda_low = 1'b0;
            @(posedge scl);
            mack = sda;
         end else begin
            shift(got);
            ackb();
         end
         @(posedge sda iff scl === 1'b1);
      end
   end
endmodule // itar_peer

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
// ==================================================================
// Bench: register map, interrupts, master write and master read.
module tb_top import itar_pkg::*;;
   logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, scl_oe, sda_oe, irq, sda_low, mack, err;
   logic [7:0] got;
   wire scl = !scl_oe;
   wire sda = !(sda_oe || sda_low);
   int mismatches = 0, comparisons = 0;
   logic [7:0] ridx [8] = '{IDX_SAR1, IDX_SAR0, IDX_CTL, IDX_IEN, IDX_CLOCK_LOW_COUNT, IDX_CLOCK_HIGH_COUNT,
      IDX_DATA_HOLD_COUNT, IDX_DATA};
   logic [7:0] rval [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h01, 8'hFF};

   // Clock at 25 MHz.
   always #20 clk = !clk;

   itar_core u_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .irq);
   itar_peer #(.RD_BYTE(8'h3C)) u_peer (.scl, .sda, .sda_low, .got, .mack);

   // ==================================================================
   // Helpers.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("BAD at %0t got %h expected %h", $time, g, e);
      end
   endtask

   // One bus transfer; the request is held until ready is seen.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      if (n == 20) mismatches++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge, so outputs launched at the access edge have settled.
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      apb(1'b1, idx, {24'h00_0000, v});
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, idx, 32'h0000_0000);
      chk(rd, {24'h00_0000, e});
   endtask

   task automatic wirq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         n++;
         @(posedge clk);
      end
      chk(32'(irq), 32'h0000_0001);
   endtask

   // Ends a transfer with a stop, then clears what it left behind.
   task automatic finish_xfer();
      int n;
      n = 0;
      wr(IDX_CTL, 8'h1E);
      wr(IDX_STAT, 8'h00);
      do begin
         apb(1'b0, IDX_STAT, 32'h0000_0000);
         n++;
      end while (rd[ST_BUSY] !== 1'b0 && n < 500);
      chk(32'(rd[ST_BUSY]), 32'h0000_0000);
      wr(IDX_STAT, 8'h00);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b0, IDX_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_0079, 32'h0000_0000);
   endtask

   task automatic wrap_up();
      if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==================================================================
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      // The pin filters need a few idle cycles before any traffic.
      repeat (6) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         rdc(ridx[i], rval[i]);
      end
      wr(IDX_SAR1, 8'h5B);
      wr(IDX_SAR0, 8'hA6);
      rdc(IDX_SAR1, 8'h5B);
      rdc(IDX_SAR0, 8'hA6);
      apb(1'b0, 8'hE0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      wr(IDX_CLOCK_LOW_COUNT, 8'h04);
      wr(IDX_CLOCK_HIGH_COUNT, 8'h03);
      wr(IDX_DATA_HOLD_COUNT, 8'h02);
      wr(IDX_IEN, 8'h78);
      // Master write: address byte, then one data byte.
      wr(IDX_DATA, 8'hA4);
      wr(IDX_CTL, 8'h1D);
      wirq();
      chk(32'(scl_oe), 32'h0000_0001);
      wr(IDX_IEN, 8'h00);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h0000_0000);
      chk(32'(scl_oe), 32'h0000_0001);
      wr(IDX_IEN, 8'h78);
      apb(1'b0, IDX_STAT, 32'h0000_0000);
      chk(rd & 32'h0000_00C1, 32'h0000_00C1);
      wr(IDX_DATA, 8'h5A);
      wr(IDX_ICLR, 8'h40);
      wirq();
      finish_xfer();
      chk({24'h00_0000, got}, 32'h0000_005A);
      // Master read: the received byte must land in the data register.
      wr(IDX_DATA, 8'hA5);
      wr(IDX_CTL, 8'h1D);
      wirq();
      wr(IDX_STAT, 8'h00);
      wirq();
      rdc(IDX_DATA, 8'h3C);
      chk(32'(mack), 32'h0000_0000);
      finish_xfer();
      wrap_up();
   end

   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
endmodule // tb_top
